// *** rtl/iebk_enable_bank.v ***
// Purpose: interrupt enable bank with per-source status flags
// Assumes: requests are synchronous to clock; AXI4-Lite register access
// Notes: forwarded requests are flag AND enable, registered once
`include "iebk_defines.vh"
`default_nettype none

// Summary of operation
// - enable one passes request, zero blocks it
// - unassigned bits read zero, ignore writes
// - implemented enable bits read/write, reset zero
// - register 0 bit 13 gates converter done
// - register 0 bits 12/11 gate UART tx/rx
// - register 0 bits 10/9 gate SPI requests
// - register 0 bits 7/3 gate timers
// - register 0 bits 2/1/0 gate compare, capture, ext0
// - register 1 bits 13/4 gate ext2, ext1
// - register 1 bits 3/2 gate change, comparator A
// - register 1 bits 1/0 gate I2C master/slave
// - register 3 bit 9 gates PWM special match
// - register 4 bit 1 gates UART error
// - register 5 bits 15/14 gate PWM generators
// - register 5 bit 0 gates test port
// - register 6 bits 15/14 gate ADC pairs 1/0
// - register 6 bit 7 gates comparator B
// - register 6 bit 1 gates PWM generator D
// - absent peripheral bits behave as unassigned
// - register 7 bits 4/1/0 gate ADC pairs 6/3/2
// - status flag sets on request, independent of enable
module iebk_enable_bank #(
  parameter ADDR_W = 8,
  parameter [127:0] IMPL_MASK = {128{1'b1}}
) (
  input wire clock,
  input wire srst,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [127:0] src_req,
  output reg [127:0] irq_req
);

  // assigned bits of a register, trimmed by the variant mask
  function [15:0] bit_mask;
    input [2:0] idx;
    reg [15:0] base;
    begin
      case (idx)
        `IEBK_IDX_0: base = `IEBK_MASK_0;
        `IEBK_IDX_1: base = `IEBK_MASK_1;
        `IEBK_IDX_3: base = `IEBK_MASK_3;
        `IEBK_IDX_4: base = `IEBK_MASK_4;
        `IEBK_IDX_5: base = `IEBK_MASK_5;
        `IEBK_IDX_6: base = `IEBK_MASK_6;
        `IEBK_IDX_7: base = `IEBK_MASK_7;
        default: base = 16'h0000;
      endcase
      bit_mask = base & IMPL_MASK[idx*16 +: 16];
    end
  endfunction

  // address hits a mapped register
  function addr_ok;
    input [ADDR_W-1:0] addr;
    begin
      addr_ok = (addr[ADDR_W-1:`IEBK_BANK_BIT+1] == {(ADDR_W-`IEBK_BANK_BIT-1){1'b0}}) &&
                (addr[`IEBK_IDX_HI:`IEBK_IDX_LO] != `IEBK_IDX_GAP);
    end
  endfunction

  reg [15:0] en_q [0:7];
  reg [15:0] flag_q [0:7];
  reg aw_held;
  reg w_held;
  reg [ADDR_W-1:0] awaddr_q;
  reg [15:0] wdata_q;
  reg [1:0] wstrb_q;
  wire wr_go;
  wire wr_hit;
  wire [2:0] wr_idx;
  wire wr_flag;
  wire [15:0] wr_lanes;
  wire [2:0] rd_idx;
  wire rd_hit;
  wire rd_flag;

  assign wr_go = aw_held & w_held & ~s_axi_bvalid;
  assign wr_hit = wr_go & addr_ok(awaddr_q);
  assign wr_idx = awaddr_q[`IEBK_IDX_HI:`IEBK_IDX_LO];
  assign wr_flag = awaddr_q[`IEBK_BANK_BIT];
  assign wr_lanes = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign rd_idx = s_axi_araddr[`IEBK_IDX_HI:`IEBK_IDX_LO];
  assign rd_hit = addr_ok(s_axi_araddr);
  assign rd_flag = s_axi_araddr[`IEBK_BANK_BIT];

  // write address and data captured independently, answered once both are in
  always @(posedge clock) begin
    if (srst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= {ADDR_W{1'b0}};
      wdata_q <= 16'h0000;
      wstrb_q <= 2'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IEBK_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_held && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wdata_q <= s_axi_wdata[15:0];
        wstrb_q <= s_axi_wstrb[1:0];
        s_axi_wready <= 1'b0;
      end else if (!w_held && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `IEBK_RESP_OKAY : `IEBK_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // read channel: one cycle from address taken to data
  always @(posedge clock) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `IEBK_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= rd_hit ? `IEBK_RESP_OKAY : `IEBK_RESP_SLVERR;
        if (!rd_hit) begin
          s_axi_rdata <= 32'h00000000;
        end else if (rd_flag) begin
          s_axi_rdata <= {16'h0000, flag_q[rd_idx]};
        end else begin
          s_axi_rdata <= {16'h0000, en_q[rd_idx]};
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // one-hot select of a register index
  function [7:0] idx_sel;
    input [2:0] idx;
    begin
      case (idx)
        3'h0: idx_sel = 8'h01;
        3'h1: idx_sel = 8'h02;
        3'h2: idx_sel = 8'h04;
        3'h3: idx_sel = 8'h08;
        3'h4: idx_sel = 8'h10;
        3'h5: idx_sel = 8'h20;
        3'h6: idx_sel = 8'h40;
        3'h7: idx_sel = 8'h80;
        default: idx_sel = 8'h00;
      endcase
    end
  endfunction

  // byte-lane merge of a write into an enable register
  function [15:0] merge_en;
    input [15:0] old;
    input [15:0] data;
    input [15:0] lanes;
    input [15:0] mask;
    begin
      merge_en = ((old & ~lanes) | (data & lanes)) & mask;
    end
  endfunction

  // a request in the clearing cycle keeps its flag set
  function [15:0] merge_flag;
    input [15:0] old;
    input [15:0] req;
    input [15:0] clr;
    input [15:0] mask;
    begin
      merge_flag = ((old & ~clr) | req) & mask;
    end
  endfunction

  // per-index selects, masks, clears and gated requests
  wire [7:0] en_sel;
  wire [7:0] flag_sel;
  wire [15:0] clr_bits;
  wire [15:0] mask_0;
  wire [15:0] mask_1;
  wire [15:0] mask_3;
  wire [15:0] mask_4;
  wire [15:0] mask_5;
  wire [15:0] mask_6;
  wire [15:0] mask_7;
  wire [15:0] clr_0;
  wire [15:0] clr_1;
  wire [15:0] clr_3;
  wire [15:0] clr_4;
  wire [15:0] clr_5;
  wire [15:0] clr_6;
  wire [15:0] clr_7;
  wire [15:0] gate_0;
  wire [15:0] gate_1;
  wire [15:0] gate_3;
  wire [15:0] gate_4;
  wire [15:0] gate_5;
  wire [15:0] gate_6;
  wire [15:0] gate_7;
  reg [15:0] fwd_0;
  reg [15:0] fwd_1;
  reg [15:0] fwd_3;
  reg [15:0] fwd_4;
  reg [15:0] fwd_5;
  reg [15:0] fwd_6;
  reg [15:0] fwd_7;
  wire [127:0] next_irq;

  assign en_sel = (wr_hit && !wr_flag) ? idx_sel(wr_idx) : 8'h00;
  assign flag_sel = (wr_hit && wr_flag) ? idx_sel(wr_idx) : 8'h00;
  assign clr_bits = wdata_q & wr_lanes;

  // assigned bits of each register
  assign mask_0 = bit_mask(`IEBK_IDX_0);
  assign mask_1 = bit_mask(`IEBK_IDX_1);
  assign mask_3 = bit_mask(`IEBK_IDX_3);
  assign mask_4 = bit_mask(`IEBK_IDX_4);
  assign mask_5 = bit_mask(`IEBK_IDX_5);
  assign mask_6 = bit_mask(`IEBK_IDX_6);
  assign mask_7 = bit_mask(`IEBK_IDX_7);

  // write-one-to-clear, only for the addressed flag register
  assign clr_0 = flag_sel[0] ? clr_bits : 16'h0000;
  assign clr_1 = flag_sel[1] ? clr_bits : 16'h0000;
  assign clr_3 = flag_sel[3] ? clr_bits : 16'h0000;
  assign clr_4 = flag_sel[4] ? clr_bits : 16'h0000;
  assign clr_5 = flag_sel[5] ? clr_bits : 16'h0000;
  assign clr_6 = flag_sel[6] ? clr_bits : 16'h0000;
  assign clr_7 = flag_sel[7] ? clr_bits : 16'h0000;

  // enable storage; masked writes keep unassigned bits at zero
  always @(posedge clock) begin
    if (srst) begin
      en_q[0] <= `IEBK_RESET_VAL;
      en_q[1] <= `IEBK_RESET_VAL;
      en_q[2] <= `IEBK_RESET_VAL;
      en_q[3] <= `IEBK_RESET_VAL;
      en_q[4] <= `IEBK_RESET_VAL;
      en_q[5] <= `IEBK_RESET_VAL;
      en_q[6] <= `IEBK_RESET_VAL;
      en_q[7] <= `IEBK_RESET_VAL;
    end else begin
      if (en_sel[0]) begin
        en_q[0] <= merge_en(en_q[0], wdata_q, wr_lanes, mask_0);
      end
      if (en_sel[1]) begin
        en_q[1] <= merge_en(en_q[1], wdata_q, wr_lanes, mask_1);
      end
      if (en_sel[3]) begin
        en_q[3] <= merge_en(en_q[3], wdata_q, wr_lanes, mask_3);
      end
      if (en_sel[4]) begin
        en_q[4] <= merge_en(en_q[4], wdata_q, wr_lanes, mask_4);
      end
      if (en_sel[5]) begin
        en_q[5] <= merge_en(en_q[5], wdata_q, wr_lanes, mask_5);
      end
      if (en_sel[6]) begin
        en_q[6] <= merge_en(en_q[6], wdata_q, wr_lanes, mask_6);
      end
      if (en_sel[7]) begin
        en_q[7] <= merge_en(en_q[7], wdata_q, wr_lanes, mask_7);
      end
    end
  end

  // status flags follow requests whatever the enables hold
  always @(posedge clock) begin
    if (srst) begin
      flag_q[0] <= `IEBK_RESET_VAL;
      flag_q[1] <= `IEBK_RESET_VAL;
      flag_q[2] <= `IEBK_RESET_VAL;
      flag_q[3] <= `IEBK_RESET_VAL;
      flag_q[4] <= `IEBK_RESET_VAL;
      flag_q[5] <= `IEBK_RESET_VAL;
      flag_q[6] <= `IEBK_RESET_VAL;
      flag_q[7] <= `IEBK_RESET_VAL;
    end else begin
      flag_q[0] <= merge_flag(flag_q[0], src_req[15:0], clr_0, mask_0);
      flag_q[1] <= merge_flag(flag_q[1], src_req[31:16], clr_1, mask_1);
      flag_q[3] <= merge_flag(flag_q[3], src_req[63:48], clr_3, mask_3);
      flag_q[4] <= merge_flag(flag_q[4], src_req[79:64], clr_4, mask_4);
      flag_q[5] <= merge_flag(flag_q[5], src_req[95:80], clr_5, mask_5);
      flag_q[6] <= merge_flag(flag_q[6], src_req[111:96], clr_6, mask_6);
      flag_q[7] <= merge_flag(flag_q[7], src_req[127:112], clr_7, mask_7);
    end
  end

  // each enable bit gates its own flag
  assign gate_0 = flag_q[0] & en_q[0];
  assign gate_1 = flag_q[1] & en_q[1];
  assign gate_3 = flag_q[3] & en_q[3];
  assign gate_4 = flag_q[4] & en_q[4];
  assign gate_5 = flag_q[5] & en_q[5];
  assign gate_6 = flag_q[6] & en_q[6];
  assign gate_7 = flag_q[7] & en_q[7];

  // forwarded requests, one line per documented source
  always @* begin
    fwd_0 = 16'h0000;
    fwd_1 = 16'h0000;
    fwd_3 = 16'h0000;
    fwd_4 = 16'h0000;
    fwd_5 = 16'h0000;
    fwd_6 = 16'h0000;
    fwd_7 = 16'h0000;
    fwd_0[`IEBK_ADC_DONE_EN] = gate_0[`IEBK_ADC_DONE_EN];
    fwd_0[`IEBK_UART_TX_EN] = gate_0[`IEBK_UART_TX_EN];
    fwd_0[`IEBK_UART_RX_EN] = gate_0[`IEBK_UART_RX_EN];
    fwd_0[`IEBK_SPI_EVENT_EN] = gate_0[`IEBK_SPI_EVENT_EN];
    fwd_0[`IEBK_SPI_SECOND_EN] = gate_0[`IEBK_SPI_SECOND_EN];
    fwd_0[`IEBK_TIMER_B_EN] = gate_0[`IEBK_TIMER_B_EN];
    fwd_0[`IEBK_TIMER_A_EN] = gate_0[`IEBK_TIMER_A_EN];
    fwd_0[`IEBK_OUT_COMPARE_EN] = gate_0[`IEBK_OUT_COMPARE_EN];
    fwd_0[`IEBK_IN_CAPTURE_EN] = gate_0[`IEBK_IN_CAPTURE_EN];
    fwd_0[`IEBK_EXT_IRQ_ZERO_EN] = gate_0[`IEBK_EXT_IRQ_ZERO_EN];
    fwd_1[`IEBK_EXT_IRQ_TWO_EN] = gate_1[`IEBK_EXT_IRQ_TWO_EN];
    fwd_1[`IEBK_EXT_IRQ_ONE_EN] = gate_1[`IEBK_EXT_IRQ_ONE_EN];
    fwd_1[`IEBK_CHANGE_NOTIFY_EN] = gate_1[`IEBK_CHANGE_NOTIFY_EN];
    fwd_1[`IEBK_COMPARATOR_A_EN] = gate_1[`IEBK_COMPARATOR_A_EN];
    fwd_1[`IEBK_I2C_MASTER_EN] = gate_1[`IEBK_I2C_MASTER_EN];
    fwd_1[`IEBK_I2C_SLAVE_EN] = gate_1[`IEBK_I2C_SLAVE_EN];
    fwd_3[`IEBK_PWM_SPECIAL_MATCH_EN] = gate_3[`IEBK_PWM_SPECIAL_MATCH_EN];
    fwd_4[`IEBK_UART_ERROR_EN] = gate_4[`IEBK_UART_ERROR_EN];
    fwd_5[`IEBK_PWM_GEN_B_EN] = gate_5[`IEBK_PWM_GEN_B_EN];
    fwd_5[`IEBK_PWM_GEN_A_EN] = gate_5[`IEBK_PWM_GEN_A_EN];
    fwd_5[`IEBK_TEST_PORT_EN] = gate_5[`IEBK_TEST_PORT_EN];
    fwd_6[`IEBK_ADC_PAIR_ONE_EN] = gate_6[`IEBK_ADC_PAIR_ONE_EN];
    fwd_6[`IEBK_ADC_PAIR_ZERO_EN] = gate_6[`IEBK_ADC_PAIR_ZERO_EN];
    fwd_6[`IEBK_COMPARATOR_B_EN] = gate_6[`IEBK_COMPARATOR_B_EN];
    fwd_6[`IEBK_PWM_GEN_D_EN] = gate_6[`IEBK_PWM_GEN_D_EN];
    fwd_7[`IEBK_ADC_PAIR_SIX_EN] = gate_7[`IEBK_ADC_PAIR_SIX_EN];
    fwd_7[`IEBK_ADC_PAIR_THREE_EN] = gate_7[`IEBK_ADC_PAIR_THREE_EN];
    fwd_7[`IEBK_ADC_PAIR_TWO_EN] = gate_7[`IEBK_ADC_PAIR_TWO_EN];
  end

  assign next_irq = {fwd_7, fwd_6, fwd_5, fwd_4, fwd_3, 16'h0000, fwd_1, fwd_0};

  // registered forward so the outputs come from flops
  always @(posedge clock) begin
    if (srst) begin
      irq_req <= {128{1'b0}};
    end else begin
      irq_req <= next_irq;
    end
  end

endmodule
`default_nettype wire

// *** rtl/iebk_defines.vh ***
// Purpose: constants for the interrupt enable bank
// Assumes: 32-bit AXI4-Lite data, 16-bit registers in the low half
// Notes: register n of a bank sits at byte offset base + 4*n
`ifndef IEBK_DEFINES_VH
`define IEBK_DEFINES_VH

// register bank bases and address decode
`define IEBK_EN_BASE 8'h00
`define IEBK_FLAG_BASE 8'h20
`define IEBK_BANK_BIT 5
`define IEBK_IDX_HI 4
`define IEBK_IDX_LO 2
`define IEBK_IDX_GAP 3'h2

// register indices
`define IEBK_IDX_0 3'h0
`define IEBK_IDX_1 3'h1
`define IEBK_IDX_3 3'h3
`define IEBK_IDX_4 3'h4
`define IEBK_IDX_5 3'h5
`define IEBK_IDX_6 3'h6
`define IEBK_IDX_7 3'h7

// field positions, enable register 0
`define IEBK_ADC_DONE_EN 13
`define IEBK_UART_TX_EN 12
`define IEBK_UART_RX_EN 11
`define IEBK_SPI_EVENT_EN 10
`define IEBK_SPI_SECOND_EN 9
`define IEBK_TIMER_B_EN 7
`define IEBK_TIMER_A_EN 3
`define IEBK_OUT_COMPARE_EN 2
`define IEBK_IN_CAPTURE_EN 1
`define IEBK_EXT_IRQ_ZERO_EN 0
// enable register 1
`define IEBK_EXT_IRQ_TWO_EN 13
`define IEBK_EXT_IRQ_ONE_EN 4
`define IEBK_CHANGE_NOTIFY_EN 3
`define IEBK_COMPARATOR_A_EN 2
`define IEBK_I2C_MASTER_EN 1
`define IEBK_I2C_SLAVE_EN 0
// enable registers 3 to 7
`define IEBK_PWM_SPECIAL_MATCH_EN 9
`define IEBK_UART_ERROR_EN 1
`define IEBK_PWM_GEN_B_EN 15
`define IEBK_PWM_GEN_A_EN 14
`define IEBK_TEST_PORT_EN 0
`define IEBK_ADC_PAIR_ONE_EN 15
`define IEBK_ADC_PAIR_ZERO_EN 14
`define IEBK_COMPARATOR_B_EN 7
`define IEBK_PWM_GEN_D_EN 1
`define IEBK_ADC_PAIR_SIX_EN 4
`define IEBK_ADC_PAIR_THREE_EN 1
`define IEBK_ADC_PAIR_TWO_EN 0

// implemented-bit masks per register
`define IEBK_MASK_0 16'h3E8F
`define IEBK_MASK_1 16'h201F
`define IEBK_MASK_3 16'h0200
`define IEBK_MASK_4 16'h0002
`define IEBK_MASK_5 16'hC001
`define IEBK_MASK_6 16'hC082
`define IEBK_MASK_7 16'h0013

// reset value of every enable and flag bit
`define IEBK_RESET_VAL 16'h0000

// bus answers
`define IEBK_RESP_OKAY 2'h0
`define IEBK_RESP_SLVERR 2'h2

`endif

// *** sim/iebk_enable_bank_properties.sv ***
// Purpose: bus and request checks
// Assumes: sees top ports only
// Notes: bound after the module
`default_nettype none
module iebk_enable_bank_props #(parameter ADDR_W = 8) (
  input wire logic clock,
  input wire logic srst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [127:0] irq_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  localparam logic [127:0] all_bits = 128'h0013C082C001000202000000201F3E8F;
  wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire rd_go = s_axi_arvalid && s_axi_arready;
  property p_b_late; wr_go |=> !s_axi_bvalid ##1 s_axi_bvalid; endproperty
  a_b_late: assert property (p_b_late) else $error("write answer timing");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_w_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_w_busy: assert property (p_w_busy) else $error("write taken too early");
  property p_r_soon; rd_go |=> s_axi_rvalid; endproperty
  a_r_soon: assert property (p_r_soon) else $error("read answer late");
  property p_r_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_r_busy: assert property (p_r_busy) else $error("read taken too early");
  property p_r_bad; rd_go && s_axi_araddr[4:2] == 3'h2 |=> s_axi_rdata == 32'h0; endproperty
  a_r_bad: assert property (p_r_bad) else $error("unmapped read data");
  property p_r_hi; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0; endproperty
  a_r_hi: assert property (p_r_hi) else $error("upper read bits set");
  property p_irq_map; (irq_req & ~all_bits) == 128'h0; endproperty
  a_irq_map: assert property (p_irq_map) else $error("unassigned request");
endmodule
bind iebk_enable_bank iebk_enable_bank_props #(.ADDR_W(ADDR_W)) u_props (.*);
`default_nettype wire

// *** sim/iebk_src_model.sv ***
// Purpose: peripheral request sources
// Assumes: one request pulse per fire cycle
// Notes: lines idle low between events
`default_nettype none
module iebk_src_model (
  input wire logic clock,
  input wire logic [127:0] fire,
  output var logic [127:0] src_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial src_req = 128'h0;
  always @(posedge clock) src_req <= fire;
endmodule
`default_nettype wire

// *** sim/iebk_enable_bank_tb.sv ***
// Purpose: register and request tests
// Assumes: 250 MHz clock, AXI4-Lite master tasks
// Notes: one source bit removed by IMPL_MASK
`include "iebk_defines.vh"
`default_nettype none
module iebk_enable_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] ok = `IEBK_RESP_OKAY;
  localparam logic [1:0] er = `IEBK_RESP_SLVERR;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic [127:0] fire = 128'h0, all_bits;
  logic [15:0] msk [8] = '{`IEBK_MASK_0 & 16'hFFFE, `IEBK_MASK_1, 16'h0000, `IEBK_MASK_3,
    `IEBK_MASK_4, `IEBK_MASK_5, `IEBK_MASK_6, `IEBK_MASK_7};
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [127:0] src_req, irq_req;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  always #2 clock = ~clock;
  iebk_enable_bank #(.ADDR_W(8), .IMPL_MASK(~128'h1)) DUT (.clock(clock), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .src_req(src_req), .irq_req(irq_req));
  iebk_src_model PEER (.clock(clock), .fire(fire), .src_req(src_req));
  task summarize;
    if (n_mismatch == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [127:0] got, input logic [127:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
    @(posedge clock);
    awaddr <= a;
    wdata <= {16'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      bready <= 1'b1;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    chk({126'h0, bresp}, {126'h0, r});
  endtask
  task rd(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      rready <= 1'b1;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    chk({96'h0, rdata}, {112'h0, d});
    chk({126'h0, rresp}, {126'h0, r});
  endtask
  task all_wr(input logic [7:0] b, input logic [15:0] d);
    foreach (msk[n]) if (n != 2) wr(b + 8'(4 * n), d, ok);
  endtask
  task all_rd(input logic [7:0] b, input logic use_mask);
    foreach (msk[n]) if (n != 2) rd(b + 8'(4 * n), use_mask ? msk[n] : 16'h0, ok);
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    foreach (msk[n]) all_bits[16*n +: 16] = msk[n];
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    all_rd(8'h00, 1'b0);
    all_wr(8'h00, 16'hFFFF);
    all_rd(8'h00, 1'b1);
    all_wr(8'h00, 16'h0000);
    all_rd(8'h00, 1'b0);
    wstrb <= 4'h1;
    wr(8'h00, 16'hFFFF, ok);
    rd(8'h00, msk[0] & 16'h00FF, ok);
    wstrb <= 4'hF;
    wr(8'h00, 16'h0000, ok);
    rd(8'h00, 16'h0000, ok);
    rd(8'h08, 16'h0, er);
    wr(8'h08, 16'hFFFF, er);
    rd(8'h40, 16'h0, er);
    @(posedge clock);
    fire <= ~128'h0;
    @(posedge clock);
    fire <= 128'h0;
    repeat (4) @(posedge clock);
    chk(irq_req, 128'h0);
    all_rd(8'h20, 1'b1);
    all_wr(8'h00, 16'hFFFF);
    repeat (2) @(posedge clock);
    chk(irq_req, all_bits);
    wr(8'h00, 16'h0000, ok);
    repeat (2) @(posedge clock);
    chk(irq_req, all_bits & ~128'hFFFF);
    all_wr(8'h20, 16'hFFFF);
    repeat (2) @(posedge clock);
    chk(irq_req, 128'h0);
    all_rd(8'h20, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
